// ### rtl/gcg_pkg.sv
// Constants shared by the clock generation block: register map, field layout,
// reset values and divider settings.
// Assumes a 40 MHz system clock and APB byte addressing with 32-bit words.
package gcg_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int          ADDR_W                 = 12;
   localparam int          REG_W                  = 8;
   localparam logic [11:0] OFS_GCI_PORT_CLOCK_SEL = 12'h240;
   localparam logic [11:0] OFS_AUX_CLOCK_OUT_CTRL = 12'h244;
   localparam logic [11:0] OFS_CORE_CLOCK_CTRL    = 12'h248;
   localparam logic [11:0] OFS_CLOCK_LOCK_BUS_DIV = 12'h24c;
   localparam logic [7:0]  RST_GCI_PORT_CLOCK_SEL = 8'h00;
   localparam logic [7:0]  RST_AUX_CLOCK_OUT_CTRL = 8'h00;
   localparam logic [7:0]  RST_CORE_CLOCK_CTRL    = 8'h00;
   localparam logic [7:0]  RST_CLOCK_LOCK_BUS_DIV = 8'h00;

   // ------------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------------
   localparam int          NUM_PORTS       = 3;
   localparam int          PORT_SEL_W      = 2;
   localparam int          MASTER_FS_LSB   = 6;
   localparam int          DIV_PAR_LSB     = 0;
   localparam int          DIV_PAR_W       = 4;
   localparam int          GATE_LSB        = 4;
   localparam logic [3:0]  GATE_OFF_CODE   = 4'h9;
   localparam int          LOCK_BIT        = 0;
   localparam int          UART_STOP_BIT   = 1;
   localparam int          BUS_DIV_LSB     = 2;

   // Per-port source codes
   localparam logic [1:0]  SRC_INACTIVE    = 2'h0;
   localparam logic [1:0]  SRC_MASTER      = 2'h1;
   localparam logic [1:0]  SRC_512K        = 2'h2;
   localparam logic [1:0]  SRC_4096K       = 2'h3;

   // Master frame-sync source codes
   localparam logic [1:0]  MFS_XTAL        = 2'h0;
   localparam logic [1:0]  MFS_PORT0       = 2'h1;
   localparam logic [1:0]  MFS_PORT1       = 2'h2;
   localparam logic [1:0]  MFS_PORT2       = 2'h3;

   // ------------------------------------------------------------------
   // Divider settings
   // ------------------------------------------------------------------
   // Bus clock half-period counts minus one for /4, /8, /16, /32
   localparam logic [3:0]  BUS_HALF_DIV4   = 4'h1;
   localparam logic [3:0]  BUS_HALF_DIV8   = 4'h3;
   localparam logic [3:0]  BUS_HALF_DIV16  = 4'h7;
   localparam logic [3:0]  BUS_HALF_DIV32  = 4'hf;

   // Synchronised pin inputs, bit positions in one vector
   localparam int          IN_MASTER_BCLK  = 0;
   localparam int          IN_XTAL_FS      = 1;
   localparam int          IN_BCLK_512K    = 2;
   localparam int          IN_FS_512K      = 3;
   localparam int          IN_BCLK_4096K   = 4;
   localparam int          IN_FS_4096K     = 5;
   localparam int          IN_PORT_FS_LSB  = 6;
   localparam int          IN_LOCK         = 9;
   localparam int          NUM_SYNC_IN     = 10;

endpackage

// ### rtl/gcg_clk_div.sv
// Glitch-free programmable clock divider with a run/stop gate.
// Assumes settings come from the same clock domain; they are sampled only
// at the end of a whole output period or while stopped.
`timescale 1ns/1ps

module gcg_clk_div #(
   parameter int DIV_W = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [DIV_W-1:0] half_par,
   input  wire logic             run,
   output logic                  clk_out
);

   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] par_ff;
   logic             run_ff;
   logic             clk_out_ff;
   logic             half_end;
   logic             period_end;

   // ------------------------------------------------------------------
   // Period tracking
   // ------------------------------------------------------------------
   // Output period is 2*(half_par+1) input cycles
   assign half_end   = (cnt_ff == par_ff);
   assign period_end = half_end & clk_out_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= '0;
      end else if (half_end | ~run_ff) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // New settings land only at a period boundary or while stopped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         par_ff <= '0;
         run_ff <= 1'b0;
      end else if (period_end | ~run_ff) begin
         par_ff <= half_par;
         run_ff <= run;
      end
   end

   // Stopping at a period end parks the output low, so no runt pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_out_ff <= 1'b0;
      end else if (~run_ff) begin
         clk_out_ff <= 1'b0;
      end else if (period_end & ~run) begin
         clk_out_ff <= 1'b0;
      end else if (half_end) begin
         clk_out_ff <= ~clk_out_ff;
      end
   end

   assign clk_out = clk_out_ff;

endmodule

// ### rtl/gcg_top.sv
// Clock generation unit: GCI port clock routing, master frame-sync choice,
// auxiliary and core clock dividers, UART clock gate, bus clock divider and
// loop lock status, all behind an APB slave with four byte-wide registers.
// Assumes all clock and sync sources arrive asynchronously and are far slower
// than clk, so they are resampled; routed outputs carry that sampling delay.
`timescale 1ns/1ps

module gcg_top (
   input  wire logic                          clk,
   input  wire logic                          rst,
   // APB slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [gcg_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                   pwdata,
   input  wire logic [3:0]                    pstrb,
   output logic                               pready,
   output logic [31:0]                        prdata,
   output logic                               pslverr,
   // Clock and sync sources
   input  wire logic                          master_bit_clock,
   input  wire logic                          xtal_frame_sync,
   input  wire logic                          bit_clock_512k,
   input  wire logic                          frame_sync_512k,
   input  wire logic                          bit_clock_4096k,
   input  wire logic                          frame_sync_4096k,
   input  wire logic [gcg_pkg::NUM_PORTS-1:0] port_frame_sync_in,
   input  wire logic                          dpll_locked,
   // Routed and generated clocks
   output logic                               master_frame_sync,
   output logic [gcg_pkg::NUM_PORTS-1:0]      port_bit_clock,
   output logic [gcg_pkg::NUM_PORTS-1:0]      port_frame_sync,
   output logic [gcg_pkg::NUM_PORTS-1:0]      port_active,
   output logic                               aux_clock_output,
   output logic                               cpu_core_clock,
   output logic                               periph_bus_clock,
   output logic                               uart_clock_enable
);
   import gcg_pkg::*;

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [REG_W-1:0]       port_sel_ff;
   logic [REG_W-1:0]       aux_ctrl_ff;
   logic [REG_W-1:0]       core_ctrl_ff;
   logic [REG_W-1:0]       lock_div_ff;
   logic                   pready_ff;
   logic [31:0]            prdata_ff;
   logic                   pslverr_ff;
   logic [31:0]            nxt_prdata;
   logic                   nxt_slverr;
   logic                   access;
   logic                   wr_en;
   logic                   hit;
   logic [NUM_SYNC_IN-1:0] raw_in;
   logic [NUM_SYNC_IN-1:0] meta_ff;
   logic [NUM_SYNC_IN-1:0] sync_ff;
   logic                   lock_ff;
   logic                   mfs_sel;
   logic                   master_fs_ff;
   logic [NUM_PORTS-1:0]   port_bclk_ff;
   logic [NUM_PORTS-1:0]   port_fs_ff;
   logic [NUM_PORTS-1:0]   port_act_ff;
   logic                   uart_en_ff;
   logic                   aux_run;
   logic                   core_run;
   logic [3:0]             bus_half;
   logic                   aux_clk;
   logic                   core_clk;
   logic                   bus_clk;
   logic                   aux_clk_ff;
   logic                   core_clk_ff;
   logic                   bus_clk_ff;

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   // One wait state so read data and completion come from flip-flops
   assign access = psel & penable;
   assign wr_en  = access & pready_ff & pwrite & pstrb[0];

   always_comb begin
      nxt_prdata = 32'h0000_0000;
      hit        = 1'b1;
      unique case (paddr)
         OFS_GCI_PORT_CLOCK_SEL: begin
            nxt_prdata[REG_W-1:0] = port_sel_ff;
         end
         OFS_AUX_CLOCK_OUT_CTRL: begin
            nxt_prdata[REG_W-1:0] = aux_ctrl_ff;
         end
         OFS_CORE_CLOCK_CTRL: begin
            nxt_prdata[REG_W-1:0] = core_ctrl_ff;
         end
         OFS_CLOCK_LOCK_BUS_DIV: begin
            nxt_prdata[REG_W-1:0] = lock_div_ff;
            nxt_prdata[LOCK_BIT]  = lock_ff;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      nxt_slverr = ~hit;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= access & ~pready_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (access & ~pready_ff) begin
         prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
         pslverr_ff <= nxt_slverr;
      end else begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end
   end

   assign pready  = pready_ff;
   assign prdata  = prdata_ff;
   assign pslverr = pslverr_ff;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_sel_ff <= RST_GCI_PORT_CLOCK_SEL;
      end else if (wr_en && paddr == OFS_GCI_PORT_CLOCK_SEL) begin
         port_sel_ff <= pwdata[REG_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aux_ctrl_ff <= RST_AUX_CLOCK_OUT_CTRL;
      end else if (wr_en && paddr == OFS_AUX_CLOCK_OUT_CTRL) begin
         aux_ctrl_ff <= pwdata[REG_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_ctrl_ff <= RST_CORE_CLOCK_CTRL;
      end else if (wr_en && paddr == OFS_CORE_CLOCK_CTRL) begin
         core_ctrl_ff <= pwdata[REG_W-1:0];
      end
   end

   // Bit 0 is never stored; it always reads the live lock flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_div_ff <= RST_CLOCK_LOCK_BUS_DIV;
      end else if (wr_en && paddr == OFS_CLOCK_LOCK_BUS_DIV) begin
         lock_div_ff <= {pwdata[REG_W-1:1], 1'b0};
      end
   end

   // ------------------------------------------------------------------
   // Input resampling
   // ------------------------------------------------------------------
   assign raw_in[IN_MASTER_BCLK]                       = master_bit_clock;
   assign raw_in[IN_XTAL_FS]                           = xtal_frame_sync;
   assign raw_in[IN_BCLK_512K]                         = bit_clock_512k;
   assign raw_in[IN_FS_512K]                           = frame_sync_512k;
   assign raw_in[IN_BCLK_4096K]                        = bit_clock_4096k;
   assign raw_in[IN_FS_4096K]                          = frame_sync_4096k;
   assign raw_in[IN_PORT_FS_LSB +: NUM_PORTS]          = port_frame_sync_in;
   assign raw_in[IN_LOCK]                              = dpll_locked;

   // At 40 MHz the 4096 kHz clock is sampled roughly ten times per period,
   // so edges carry up to one cycle of jitter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= raw_in;
         sync_ff <= meta_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_ff <= 1'b0;
      end else begin
         lock_ff <= sync_ff[IN_LOCK];
      end
   end

   // ------------------------------------------------------------------
   // Master frame sync
   // ------------------------------------------------------------------
   always_comb begin
      unique case (port_sel_ff[MASTER_FS_LSB +: PORT_SEL_W])
         MFS_XTAL:  mfs_sel = sync_ff[IN_XTAL_FS];
         MFS_PORT0: mfs_sel = sync_ff[IN_PORT_FS_LSB];
         MFS_PORT1: mfs_sel = sync_ff[IN_PORT_FS_LSB+1];
         MFS_PORT2: mfs_sel = sync_ff[IN_PORT_FS_LSB+2];
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         master_fs_ff <= 1'b0;
      end else begin
         master_fs_ff <= mfs_sel;
      end
   end

   assign master_frame_sync = master_fs_ff;

   // ------------------------------------------------------------------
   // Per-port clock routing
   // ------------------------------------------------------------------
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         logic [PORT_SEL_W-1:0] src;
         logic                  nxt_bclk;
         logic                  nxt_fs;

         assign src = port_sel_ff[gp*PORT_SEL_W +: PORT_SEL_W];

         always_comb begin
            unique case (src)
               SRC_INACTIVE: begin
                  nxt_bclk = 1'b0;
                  nxt_fs   = 1'b0;
               end
               SRC_MASTER: begin
                  nxt_bclk = sync_ff[IN_MASTER_BCLK];
                  nxt_fs   = master_fs_ff;
               end
               SRC_512K: begin
                  nxt_bclk = sync_ff[IN_BCLK_512K];
                  nxt_fs   = sync_ff[IN_FS_512K];
               end
               SRC_4096K: begin
                  nxt_bclk = sync_ff[IN_BCLK_4096K];
                  nxt_fs   = sync_ff[IN_FS_4096K];
               end
            endcase
         end

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               port_bclk_ff[gp] <= 1'b0;
               port_fs_ff[gp]   <= 1'b0;
               port_act_ff[gp]  <= 1'b0;
            end else begin
               port_bclk_ff[gp] <= nxt_bclk;
               port_fs_ff[gp]   <= nxt_fs;
               port_act_ff[gp]  <= (src != SRC_INACTIVE);
            end
         end
      end
   endgenerate

   assign port_bit_clock  = port_bclk_ff;
   assign port_frame_sync = port_fs_ff;
   assign port_active     = port_act_ff;

   // ------------------------------------------------------------------
   // Generated clocks
   // ------------------------------------------------------------------
   assign aux_run  = (aux_ctrl_ff[GATE_LSB +: 4] != GATE_OFF_CODE);
   assign core_run = (core_ctrl_ff[GATE_LSB +: 4] != GATE_OFF_CODE);

   always_comb begin
      unique case (lock_div_ff[BUS_DIV_LSB +: 2])
         2'h0: bus_half = BUS_HALF_DIV4;
         2'h1: bus_half = BUS_HALF_DIV8;
         2'h2: bus_half = BUS_HALF_DIV16;
         2'h3: bus_half = BUS_HALF_DIV32;
      endcase
   end

   gcg_clk_div #(
      .DIV_W    (DIV_PAR_W)
   ) u_aux_div (
      .clk      (clk),
      .rst      (rst),
      .half_par (aux_ctrl_ff[DIV_PAR_LSB +: DIV_PAR_W]),
      .run      (aux_run),
      .clk_out  (aux_clk)
   );

   gcg_clk_div #(
      .DIV_W    (DIV_PAR_W)
   ) u_core_div (
      .clk      (clk),
      .rst      (rst),
      .half_par (core_ctrl_ff[DIV_PAR_LSB +: DIV_PAR_W]),
      .run      (core_run),
      .clk_out  (core_clk)
   );

   // Bus divider never stops; a dead bus clock would lock out software
   gcg_clk_div #(
      .DIV_W    (4)
   ) u_bus_div (
      .clk      (clk),
      .rst      (rst),
      .half_par (bus_half),
      .run      (1'b1),
      .clk_out  (bus_clk)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aux_clk_ff  <= 1'b0;
         core_clk_ff <= 1'b0;
         bus_clk_ff  <= 1'b0;
      end else begin
         aux_clk_ff  <= aux_clk;
         core_clk_ff <= core_clk;
         bus_clk_ff  <= bus_clk;
      end
   end

   assign aux_clock_output = aux_clk_ff;
   assign cpu_core_clock   = core_clk_ff;
   assign periph_bus_clock = bus_clk_ff;

   // ------------------------------------------------------------------
   // UART clock gate
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         uart_en_ff <= 1'b1;
      end else begin
         uart_en_ff <= ~lock_div_ff[UART_STOP_BIT];
      end
   end

   assign uart_clock_enable = uart_en_ff;

endmodule

// ### test/gcg_src_model.sv
// Far-side sources: GCI bit clocks, frame syncs and the loop lock flag.
// Assumes it shares clk; every clock and sync is a slow wave from one counter, and the lock flag follows lock_req.
`timescale 1ns/1ps

module gcg_src_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       lock_req,
   output logic            master_bit_clock,
   output logic            xtal_frame_sync,
   output logic            bit_clock_512k,
   output logic            frame_sync_512k,
   output logic            bit_clock_4096k,
   output logic            frame_sync_4096k,
   output logic [2:0]      port_frame_sync_in,
   output logic            dpll_locked
);
   logic [9:0] cnt_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 10'h000;
      end else begin
         cnt_ff <= cnt_ff + 10'h001;
      end
   end

   // Distinct rates so a wrong route cannot match by accident
   assign master_bit_clock   = cnt_ff[4];
   assign bit_clock_512k     = cnt_ff[5];
   assign bit_clock_4096k    = cnt_ff[3];
   assign frame_sync_512k    = cnt_ff[8];
   assign frame_sync_4096k   = cnt_ff[6];
   assign xtal_frame_sync    = cnt_ff[7];
   assign port_frame_sync_in = {cnt_ff[9], cnt_ff[8] ^ cnt_ff[6], cnt_ff[7] ^ cnt_ff[5]};
   assign dpll_locked        = lock_req;
endmodule

// ### test/gcg_top_assertions.sv
// Checker for gcg_top, watching its ports only.
// Assumes APB writes; two registers are shadowed from completed writes.
`timescale 1ns/1ps

module gcg_chk (
   input wire logic                          clk,
   input wire logic                          rst,
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic                          pwrite,
   input wire logic [gcg_pkg::ADDR_W-1:0]    paddr,
   input wire logic [31:0]                   pwdata,
   input wire logic [3:0]                    pstrb,
   input wire logic                          pready,
   input wire logic [31:0]                   prdata,
   input wire logic                          xtal_frame_sync,
   input wire logic                          master_frame_sync,
   input wire logic [gcg_pkg::NUM_PORTS-1:0] port_bit_clock,
   input wire logic [gcg_pkg::NUM_PORTS-1:0] port_frame_sync,
   input wire logic [gcg_pkg::NUM_PORTS-1:0] port_active,
   input wire logic                          periph_bus_clock,
   input wire logic                          uart_clock_enable
);
   import gcg_pkg::*;
   logic       wr;
   logic [7:0] sel_ff;
   logic [7:0] ctl_ff;

   assign wr = psel & penable & pready & pwrite & pstrb[0];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_ff <= 8'h00;
      end else if (wr && paddr == OFS_GCI_PORT_CLOCK_SEL) begin
         sel_ff <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl_ff <= 8'h00;
      end else if (wr && paddr == OFS_CLOCK_LOCK_BUS_DIV) begin
         ctl_ff <= pwdata[7:0];
      end
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);

   port_map_a: assert property ($stable(sel_ff) [*3] |->
      port_active == {|sel_ff[5:4], |sel_ff[3:2], |sel_ff[1:0]}) else $error("port enables wrong");
   idle_zero_a: assert property ((port_active == 3'h0) [*5] |->
      port_bit_clock == 3'h0 && port_frame_sync == 3'h0) else $error("idle port drives");
   mfs_xtal_a: assert property ((sel_ff[7:6] == MFS_XTAL && $stable(xtal_frame_sync)) [*6]
      |-> master_frame_sync == xtal_frame_sync) else $error("master sync not crystal");
   reset_out_a: assert property ($fell(rst) |-> port_active == 3'h0 &&
      !master_frame_sync && uart_clock_enable) else $error("outputs not reset");
   uart_gate_a: assert property (wr && paddr == OFS_CLOCK_LOCK_BUS_DIV |-> ##2
      uart_clock_enable != ctl_ff[UART_STOP_BIT]) else $error("uart gate wrong");
   read_back_a: assert property (pready && !pwrite && paddr == OFS_CLOCK_LOCK_BUS_DIV
      |-> prdata[7:1] == ctl_ff[7:1]) else $error("status readback wrong");
   high_byte_a: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   bus_min_a: assert property ($rose(periph_bus_clock) |=> periph_bus_clock)
      else $error("bus clock high too short");
   bus_max_a: assert property ($rose(periph_bus_clock) |-> ##[1:16] $fell(periph_bus_clock))
      else $error("bus clock high too long");
endmodule

// ### test/gcg_top_bench.sv
// Self-checking bench for gcg_top: registers, routing and dividers.
// Assumes the source model shares clk; the checker is bound at the foot.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end

module gcg_top_bench;
   import gcg_pkg::*;
   localparam logic [47:0] OFS = {OFS_CLOCK_LOCK_BUS_DIV, OFS_CORE_CLOCK_CTRL,
                                  OFS_AUX_CLOCK_OUT_CTRL, OFS_GCI_PORT_CLOCK_SEL};
   logic              clk, rst, psel, penable, pwrite, lock_req, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic [3:0]        pstrb;
   logic              master_bit_clock, xtal_frame_sync, bit_clock_512k, frame_sync_512k;
   logic              bit_clock_4096k, frame_sync_4096k, dpll_locked, master_frame_sync;
   logic              aux_clock_output, cpu_core_clock, periph_bus_clock, uart_clock_enable;
   logic [2:0]        port_frame_sync_in, port_bit_clock, port_frame_sync, port_active, g;
   logic [9:0]        s, h1, h2, h3;
   int                miscompares = 0, check_count = 0, cycles = 0;

   assign s = {frame_sync_4096k, frame_sync_512k, port_frame_sync_in, xtal_frame_sync,
               bit_clock_4096k, bit_clock_512k, master_bit_clock, 1'b0};
   assign g = {periph_bus_clock, cpu_core_clock, aux_clock_output};

   gcg_top u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
      .prdata, .pslverr, .master_bit_clock, .xtal_frame_sync, .bit_clock_512k,
      .frame_sync_512k, .bit_clock_4096k, .frame_sync_4096k, .port_frame_sync_in,
      .dpll_locked, .master_frame_sync, .port_bit_clock, .port_frame_sync, .port_active,
      .aux_clock_output, .cpu_core_clock, .periph_bus_clock, .uart_clock_enable);
   gcg_src_model u_src (.clk, .rst, .lock_req, .master_bit_clock, .xtal_frame_sync,
      .bit_clock_512k, .frame_sync_512k, .bit_clock_4096k, .frame_sync_4096k,
      .port_frame_sync_in, .dpll_locked);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Sources three edges ago line up with the resampled routed outputs
   always @(posedge clk) begin
      h1 <= s;
      h2 <= h1;
      h3 <= h2;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end

   task automatic final_report();
      if (miscompares == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] b, output logic [31:0] r, output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      pstrb   <= b;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, 4'h1, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 8'h00, 4'h0, r, e);
      `CHK(r, {24'h0, x})
      `CHK(e, xe)
   endtask

   // Skip to a rising edge and one full period, then count the next one
   task automatic per(input int k, input int x);
      int   n;
      logic p;
      repeat (3) begin
         n = 0;
         do begin
            p = g[k];
            @(negedge clk);
            n++;
         end while (g[k] !== 1'b1 || p !== 1'b0);
      end
      `CHK(n, x)
   endtask

   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         rd(OFS[i*12 +: 12], 8'h00, 1'b0);
      end
      `CHK(port_active, 3'h0)
      `CHK(uart_clock_enable, 1'b1)
   endtask

   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      for (int i = 0; i < 4; i++) begin
         wr(OFS[i*12 +: 12], 8'ha5);
         rd(OFS[i*12 +: 12], (i == 3) ? 8'ha4 : 8'ha5, 1'b0);
      end
      apb(1'b1, OFS_AUX_CLOCK_OUT_CTRL, 8'h3c, 4'h0, r, e);
      rd(OFS_AUX_CLOCK_OUT_CTRL, 8'ha5, 1'b0);
      rd(12'h250, 8'h00, 1'b1);
      @(posedge clk);
      lock_req <= 1'b1;
      repeat (8) @(posedge clk);
      rd(OFS_CLOCK_LOCK_BUS_DIV, 8'ha5, 1'b0);
      `CHK(uart_clock_enable, 1'b1)
      wr(OFS_CLOCK_LOCK_BUS_DIV, 8'h02);
      repeat (3) @(negedge clk);
      `CHK(uart_clock_enable, 1'b0)
   endtask

   task automatic t_route();
      logic m;
      for (int p = 0; p < 3; p++) begin
         for (int c = 0; c < 4; c++) begin
            wr(OFS_GCI_PORT_CLOCK_SEL, 8'((c << 6) | (c << (2 * p))));
            repeat (8) @(negedge clk);
            `CHK(port_active, (c != 0 ? 3'h1 : 3'h0) << p)
            repeat (40) begin
               m = master_frame_sync;
               @(negedge clk);
               `CHK(port_bit_clock, 3'(h3[c]) << p)
               `CHK(master_frame_sync, h3[4+c])
               `CHK(port_frame_sync, 3'(c == 1 ? m : c > 1 && h3[6+c]) << p)
            end
         end
      end
   endtask

   task automatic t_div();
      logic [7:0] v;
      int         n;
      for (int i = 0; i < 3; i++) begin
         v = 8'(24'h1fa680 >> (8 * i));
         wr(OFS_AUX_CLOCK_OUT_CTRL, v);
         wr(OFS_CORE_CLOCK_CTRL, v);
         per(0, 2 * (int'(v[3:0]) + 1));
         per(1, 2 * (int'(v[3:0]) + 1));
      end
      wr(OFS_AUX_CLOCK_OUT_CTRL, 8'h93);
      wr(OFS_CORE_CLOCK_CTRL, 8'h9f);
      repeat (48) @(negedge clk);
      n = 0;
      repeat (48) begin
         @(negedge clk);
         n += int'(g[0] | g[1]);
      end
      `CHK(n, 0)
      for (int f = 0; f < 4; f++) begin
         wr(OFS_CLOCK_LOCK_BUS_DIV, {4'h0, 2'(f), 2'b00});
         per(2, 4 << f);
      end
   endtask

   initial begin
      rst      = 1'b1;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = '0;
      pwdata   = 32'h0;
      pstrb    = 4'h0;
      lock_req = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_route();
      t_div();
      final_report();
   end
endmodule

bind gcg_top gcg_chk u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .pready, .prdata, .xtal_frame_sync, .master_frame_sync, .port_bit_clock,
   .port_frame_sync, .port_active, .periph_bus_clock, .uart_clock_enable);
